// [logic/edc_params.svh]
`ifndef EDC_PARAMS_SVH
`define EDC_PARAMS_SVH
// ------------------------------------------------------------
// clock and conversion
// ------------------------------------------------------------
`define EDC_CLK_NS          8
`define EDC_CYC_UP(t)       (((t) + `EDC_CLK_NS - 1) / `EDC_CLK_NS)
`define EDC_CYC_DN(t)       ((t) / `EDC_CLK_NS)
`define EDC_MAX(a, b)       (((a) > (b)) ? (a) : (b))
// ------------------------------------------------------------
// memory timing, fastest grade, in ns
// ------------------------------------------------------------
`define EDC_T_RAS_MIN_NS    50
`define EDC_T_RAS_MAX_NS    10000
`define EDC_T_RASP_MAX_NS   100000
`define EDC_T_RP_NS         30
`define EDC_T_CBR_WE_NS     10
`define EDC_T_CSR_NS        5
`define EDC_T_CHR_NS        10
`define EDC_T_RCD_NS        12
`define EDC_T_CAC_NS        13
`define EDC_T_WCH_NS        8
`define EDC_T_WP_NS         8
`define EDC_T_CLCH_NS       5
`define EDC_T_INIT_NS       200000
`define EDC_T_REFI_NS       15625
// ------------------------------------------------------------
// derived counts and layout
// ------------------------------------------------------------
`define EDC_SYNC_STAGES     2
`define EDC_INIT_CYCLES     8
`define EDC_RAS_CYC         `EDC_CYC_UP(`EDC_T_RAS_MIN_NS)
`define EDC_RP_CYC          `EDC_CYC_UP(`EDC_T_RP_NS)
`define EDC_CSR_CYC         `EDC_MAX(`EDC_CYC_UP(`EDC_T_CBR_WE_NS), `EDC_CYC_UP(`EDC_T_CSR_NS))
`define EDC_RCD_CYC         `EDC_CYC_UP(`EDC_T_RCD_NS)
`define EDC_RD_CYC          (`EDC_CYC_UP(`EDC_T_CAC_NS) + `EDC_SYNC_STAGES)
`define EDC_WR_CYC          `EDC_MAX(`EDC_CYC_UP(`EDC_T_WCH_NS), `EDC_CYC_UP(`EDC_T_CLCH_NS))
`define EDC_ADDR_W          20
`define EDC_COL_W           10
`define EDC_DATA_W          16
`define EDC_FIFO_DEPTH      4
`endif

// [logic/edc_pkg.sv]
`default_nettype none
`include "edc_params.svh"
package edc_pkg;
  // one-hot controller states
  typedef enum logic [7:0] {
    ST_INIT = 8'h01,
    ST_IDLE = 8'h02,
    ST_RCAS = 8'h04,
    ST_RRAS = 8'h08,
    ST_ROW  = 8'h10,
    ST_COL  = 8'h20,
    ST_CAS  = 8'h40,
    ST_END  = 8'h80
  } edc_state_type;

  // one user request as it travels through the fifo
  typedef struct packed {
    logic                    wr;
    logic [1:0]              be;
    logic [`EDC_ADDR_W-1:0]  addr;
    logic [`EDC_DATA_W-1:0]  data;
  } edc_req_type;

  // memory pins driven by the controller
  typedef struct packed {
    logic                    row_strobe_n;
    logic                    low_byte_column_strobe_n;
    logic                    high_byte_column_strobe_n;
    logic                    write_n;
    logic                    output_enable_n;
    logic [`EDC_COL_W-1:0]   addr;
    logic [`EDC_DATA_W-1:0]  dq_o;
    logic                    dq_oe;
  } edc_pins_type;

  // all strobes inactive, bus released
  localparam edc_pins_type EDC_PINS_IDLE = '{row_strobe_n: 1'b1,
    low_byte_column_strobe_n: 1'b1, high_byte_column_strobe_n: 1'b1,
    write_n: 1'b1, output_enable_n: 1'b1, default: '0};

  // whole controller state
  typedef struct packed {
    edc_state_type           st;
    logic [31:0]             cnt;
    logic [31:0]             ras_age;
    logic [31:0]             refi;
    logic [3:0]              init_left;
    logic                    ref_pend;
    edc_req_type             req;
    edc_pins_type            pins;
    logic [`EDC_DATA_W-1:0]  sync1;
    logic [`EDC_DATA_W-1:0]  sync2;
    logic [`EDC_DATA_W-1:0]  rd_data;
    logic                    rd_valid;
  } edc_ctrl_type;
endpackage : edc_pkg
`default_nettype wire

// [logic/edc_ctrl.sv]
// Summary of operation
// - page-mode row strobe active no longer than 100 000 ns.
// - non-page row strobe active between 50 ns and 10 000 ns.
// - row strobe precharge at least 30 ns between activations.
// - refresh: write enable level set 10 ns before and after row strobe fall.
// - refresh: column strobe low 5 ns before row strobe falls, held afterwards.
// - early write: write enable low by column strobe fall, held 8 ns.
// - write data setup 0 ns, hold 8 ns against later strobe or enable.
// - read command ends with hold vs column or row strobe rise.
// - read-write: write enable at least 67 ns after row strobe fall.
// - read-write: write enable at least 30 ns after column strobe fall.
// - memory takes column address on first column fall; hold it 5 ns.
// - write lead to column strobe met for each column strobe used.
// - early write data timed per lane against that lane's strobe.
// - wait 5 ns after row strobe rise before lowering a column strobe.
// - column address 10 to 25 ns after row strobe falls.
// - row strobe stays active 8 ns after last column strobe falls.
// - write enable pulse at least 8 ns per write command.
// - after power-up pause 200 us, then eight cycles including a refresh.
`timescale 1ns/100ps
`default_nettype none
`include "edc_params.svh"

// ------------------------------------------------------------
// request fifo
// ------------------------------------------------------------
module edc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = `EDC_FIFO_DEPTH
) (
  input  wire logic             ref_clk,     // system clock
  input  wire logic             reset,       // async reset, active high
  input  wire logic [WIDTH-1:0] in_data,     // word to store
  input  wire logic             in_valid,    // producer has a word
  output logic                  in_ready,    // room for a word
  output logic [WIDTH-1:0]      out_data,    // oldest word
  output logic                  out_valid,   // fifo holds a word
  input  wire logic             out_ready    // consumer takes the word
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // depth must be a power of two so the pointers wrap by themselves
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("edc_fifo depth must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
  } edc_fifo_type;

  edc_fifo_type s_q;
  edc_fifo_type s_d;
  logic         push;
  logic         pop;

  // honest flags straight from the fill count
  assign in_ready  = (s_q.count != (AW+1)'(DEPTH));
  assign out_valid = (s_q.count != '0);
  assign out_data  = s_q.mem[s_q.rptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer and count update
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wptr] = in_data;
      s_d.wptr          = s_q.wptr + 1'b1;
    end
    if (pop) begin
      s_d.rptr = s_q.rptr + 1'b1;
    end
    if (push && !pop) begin
      s_d.count = s_q.count + 1'b1;
    end else if (pop && !push) begin
      s_d.count = s_q.count - 1'b1;
    end
  end

  // state register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : edc_fifo

// ------------------------------------------------------------
// memory controller
// ------------------------------------------------------------
module edc_ctrl #(
  parameter int unsigned INIT_CYC = `EDC_CYC_UP(`EDC_T_INIT_NS),
  parameter int unsigned REFI_CYC = `EDC_CYC_DN(`EDC_T_REFI_NS)
) (
  input  wire logic                   ref_clk,    // system clock, 125 MHz
  input  wire logic                   reset,      // async reset, active high
  input  wire edc_pkg::edc_req_type   req,        // access request
  input  wire logic                   req_valid,  // request offered
  output logic                        req_ready,  // request taken
  output logic [`EDC_DATA_W-1:0]      rd_data,    // read result
  output logic                        rd_valid,   // read result pulse
  output edc_pkg::edc_pins_type       mem_pins,   // strobes, address, dq drive
  input  wire logic [`EDC_DATA_W-1:0] dq_i        // dq pin level
);
  import edc_pkg::*;

  // long counts must fit the 32-bit counters; init count nonzero, refresh interval at least two row cycles
  if (INIT_CYC < 1 || REFI_CYC < 2 * (`EDC_RAS_CYC + `EDC_RP_CYC)) begin : g_bad_par
    $error("edc_ctrl init or refresh count out of range");
  end

  edc_ctrl_type s_q;
  edc_ctrl_type s_d;
  edc_req_type  fifo_req;
  logic         fifo_valid;
  logic         fifo_pop;

  // ------------------------------------------------------------
  // request buffer
  // ------------------------------------------------------------
  // the controller stalls the buffer while busy, so it can fill up
  edc_fifo #(
    .WIDTH ($bits(edc_req_type)),
    .DEPTH (`EDC_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_data   (req),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .out_data  (fifo_req),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  assign mem_pins = s_q.pins;
  assign rd_data  = s_q.rd_data;
  assign rd_valid = s_q.rd_valid;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  // a single cycle per row activation keeps every access non-page,
  // trading bandwidth for a fixed and short row strobe pulse;
  // refresh wins over a waiting request, so a queued access may wait
  // one refresh cycle, or all eight after power-up, but traffic delays a refresh by at most the access in flight
  always_comb begin
    s_d          = s_q;
    fifo_pop     = 1'b0;
    s_d.rd_valid = 1'b0;
    // dq pins are asynchronous to ref_clk: two stages before use
    s_d.sync1    = dq_i;
    s_d.sync2    = s_q.sync1;
    if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - 32'd1;
    end
    // age of the current row activation
    if (s_q.pins.row_strobe_n) begin
      s_d.ras_age = '0;
    end else begin
      s_d.ras_age = s_q.ras_age + 32'd1;
    end
    case (s_q.st)
      ST_INIT: begin
        // power-up pause before any strobe moves
        // the fifo keeps taking requests meanwhile; they wait, none is lost
        if (s_q.cnt == '0) begin
          s_d.st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (s_q.init_left != '0 || s_q.ref_pend) begin
          // both column strobes first, write enable held high
          s_d.st                                 = ST_RCAS;
          s_d.pins.low_byte_column_strobe_n      = 1'b0;
          s_d.pins.high_byte_column_strobe_n     = 1'b0;
          s_d.pins.write_n                       = 1'b1;
          s_d.cnt = 32'(`EDC_CSR_CYC - 1);
        end else if (fifo_valid) begin
          // plain read or early write only; read-write is never issued,
          // so the late write enable delays hold trivially
          fifo_pop               = 1'b1;
          s_d.req                = fifo_req;
          s_d.st                 = ST_ROW;
          s_d.pins.row_strobe_n  = 1'b0;
          s_d.pins.addr          = fifo_req.addr[`EDC_ADDR_W-1:`EDC_COL_W];
          s_d.cnt = 32'(`EDC_RCD_CYC - 1);
        end
      end
      ST_RCAS: begin
        if (s_q.cnt == '0) begin
          s_d.st                = ST_RRAS;
          s_d.pins.row_strobe_n = 1'b0;
          s_d.cnt = 32'(`EDC_RAS_CYC - 1);
        end
      end
      ST_RRAS: begin
        // column strobes and write enable stay put for the whole pulse
        if (s_q.cnt == '0) begin
          s_d.st   = ST_END;
          s_d.pins = EDC_PINS_IDLE;
          s_d.cnt  = 32'(`EDC_RP_CYC - 1);
          s_d.ref_pend = 1'b0;
          if (s_q.init_left != '0) begin
            s_d.init_left = s_q.init_left - 4'd1;
          end
        end
      end
      ST_ROW: begin
        // row hold met, column address goes out a cycle ahead of the strobe
        if (s_q.cnt == '0) begin
          s_d.st                   = ST_COL;
          s_d.pins.addr            = s_q.req.addr[`EDC_COL_W-1:0];
          s_d.pins.write_n         = ~s_q.req.wr;
          s_d.pins.output_enable_n = s_q.req.wr;
          s_d.pins.dq_o            = s_q.req.data;
          s_d.pins.dq_oe           = s_q.req.wr;
          s_d.cnt = '0;
        end
      end
      ST_COL: begin
        // reads drop both strobes; writes only the enabled lanes
        s_d.st = ST_CAS;
        s_d.pins.low_byte_column_strobe_n  = s_q.req.wr & ~s_q.req.be[0];
        s_d.pins.high_byte_column_strobe_n = s_q.req.wr & ~s_q.req.be[1];
        if (s_q.req.wr) begin
          s_d.cnt = 32'(`EDC_WR_CYC - 1);
        end else begin
          s_d.cnt = 32'(`EDC_RD_CYC - 1);
        end
      end
      ST_CAS: begin
        // both lanes rise together; data and write enable stay driven
        // read data comes from the second sync stage, so the strobe stays
        // low long enough to cover the access time plus both stages
        if (s_q.cnt == '0) begin
          s_d.pins.low_byte_column_strobe_n  = 1'b1;
          s_d.pins.high_byte_column_strobe_n = 1'b1;
          s_d.st = ST_END;
          s_d.cnt = '0;
          if (!s_q.req.wr) begin
            s_d.rd_data  = s_q.sync2;
            s_d.rd_valid = 1'b1;
          end
        end
      end
      ST_END: begin
        // row strobe rises only after its least pulse; it then doubles as
        // precharge wait, counted from the row strobe rise
        if (!s_q.pins.row_strobe_n) begin
          // closing after the least pulse keeps every activation far
          // below both the page and non-page upper limits
          if (s_q.ras_age >= 32'(`EDC_RAS_CYC)) begin
            s_d.pins = EDC_PINS_IDLE;
            s_d.cnt  = 32'(`EDC_RP_CYC - 1);
          end
        end else if (s_q.cnt == '0) begin
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        s_d.st   = ST_END;
        s_d.pins = EDC_PINS_IDLE;
        s_d.cnt  = 32'(`EDC_RP_CYC - 1);
      end
    endcase
    // refresh tick last, so a tick in the clearing cycle is kept
    if (s_q.refi >= 32'(REFI_CYC - 1)) begin
      s_d.refi     = '0;
      s_d.ref_pend = 1'b1;
    end else begin
      s_d.refi = s_q.refi + 32'd1;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      // restart the power-up pause with every pin parked inactive
      s_q           <= '0;
      s_q.st        <= ST_INIT;
      s_q.cnt       <= 32'(INIT_CYC - 1);
      s_q.init_left <= 4'(`EDC_INIT_CYCLES);
      s_q.pins      <= EDC_PINS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : edc_ctrl
`default_nettype wire

// [tb/edc_ctrl_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
`include "edc_params.svh"
// ------------------------------------------------------------
// pin protocol checker
// ------------------------------------------------------------
module edc_ctrl_assertions #(
  parameter int unsigned INIT_CYC = 20,
  parameter int unsigned REFI_CYC = 40
) (
  input wire logic                   ref_clk,   // system clock
  input wire logic                   reset,     // async reset
  input wire edc_pkg::edc_req_type   req,       // request
  input wire logic                   req_valid, // request offered
  input wire logic                   req_ready, // request taken
  input wire logic [`EDC_DATA_W-1:0] rd_data,   // read result
  input wire logic                   rd_valid,  // read pulse
  input wire edc_pkg::edc_pins_type  mem_pins,  // memory pins
  input wire logic [`EDC_DATA_W-1:0] dq_i       // dq level
);
  import edc_pkg::*;
  logic        rn, ln, hn, wn, oen;
  logic [31:0] up_q;
  logic [31:0] gap_q;
  logic [3:0]  nref_q;
  // the five strobes sit at the top of the pin struct
  assign {rn, ln, hn, wn, oen} = mem_pins[31:27];
  // a row fall with a column already low is a refresh; count them
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      up_q   <= '0;
      gap_q  <= '0;
      nref_q <= '0;
    end else begin
      up_q  <= up_q + 32'h1;
      gap_q <= ($fell(rn) && !ln) ? 32'h0 : gap_q + 32'h1;
      if ($fell(rn) && !ln && nref_q != 4'hf)
        nref_q <= nref_q + 4'h1;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_ras_min; $fell(rn) |-> !rn [*7]; endproperty
  a_ras_min: assert property (p_ras_min)
    else $error("row pulse short");
  property p_ras_max; $fell(rn) |-> ##[1:1000] $rose(rn); endproperty
  a_ras_max: assert property (p_ras_max)
    else $error("row pulse long");
  property p_precharge; $rose(rn) |-> rn [*4]; endproperty
  a_precharge: assert property (p_precharge)
    else $error("precharge short");
  property p_cbr_we; $fell(rn) && !ln |-> wn && $past(wn) && $past(wn, 2) ##1 wn ##1 wn;
  endproperty
  a_cbr_we: assert property (p_cbr_we)
    else $error("write level moved near refresh");
  property p_cbr_col; $fell(rn) && !(ln && hn) |-> $past(!ln && !hn) && !ln && !hn
    ##1 !ln && !hn; endproperty
  a_cbr_col: assert property (p_cbr_col)
    else $error("refresh column timing");
  property p_col_after_row; $rose(rn) |-> ln && hn; endproperty
  a_col_after_row: assert property (p_col_after_row)
    else $error("column low at row rise");
  property p_row_addr; $fell(rn) && ln && hn |=> $stable(mem_pins.addr); endproperty
  a_row_addr: assert property (p_row_addr)
    else $error("row address hold");
  property p_col_addr; ($fell(ln) || $fell(hn)) && !rn |-> $stable(mem_pins.addr)
    ##1 $stable(mem_pins.addr) && !rn; endproperty
  a_col_addr: assert property (p_col_addr)
    else $error("column address or row hold");
  property p_early_write; ($fell(ln) || $fell(hn)) && !rn && !wn |-> $past(!wn)
    && mem_pins.dq_oe && $stable(mem_pins.dq_o) ##1 !wn && $stable(mem_pins.dq_o);
  endproperty
  a_early_write: assert property (p_early_write)
    else $error("early write timing");
  property p_read_end; rd_valid |-> $rose(ln) && $rose(hn) && wn ##1 !rd_valid; endproperty
  a_read_end: assert property (p_read_end)
    else $error("read end");
  property p_no_rmw; $fell(wn) |-> ln && hn && oen; endproperty
  a_no_rmw: assert property (p_no_rmw)
    else $error("write after column fall");
  property p_init_pause; $fell(rn) || $fell(ln) |-> up_q >= INIT_CYC; endproperty
  a_init_pause: assert property (p_init_pause)
    else $error("init pause short");
  property p_init_refs; $fell(wn) || $fell(oen) |-> nref_q >= 4'h8; endproperty
  a_init_refs: assert property (p_init_refs)
    else $error("access before init refreshes");
  property p_ref_gap; nref_q != 4'h0 |-> gap_q <= REFI_CYC + 40; endproperty
  a_ref_gap: assert property (p_ref_gap)
    else $error("refresh gap long");
endmodule : edc_ctrl_assertions

bind edc_ctrl edc_ctrl_assertions #(.INIT_CYC(INIT_CYC), .REFI_CYC(REFI_CYC)) u_chk (
  .ref_clk(ref_clk), .reset(reset), .req(req), .req_valid(req_valid),
  .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid),
  .mem_pins(mem_pins), .dq_i(dq_i));
`default_nettype wire

// [tb/edc_mem_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// memory device model
// ------------------------------------------------------------
module edc_mem_model (
  input wire edc_pkg::edc_pins_type pins, // controller pins
  output logic [15:0]               dq    // level the memory drives
);
  import edc_pkg::*;
  logic [15:0] mem [int];
  logic [9:0]  row_q;
  logic [9:0]  col_q;
  logic        cbr_q;
  logic [15:0] last_q = 16'h0000;
  logic        col_low;
  logic        drive;
  logic [15:0] word;
  assign col_low = !(pins.low_byte_column_strobe_n && pins.high_byte_column_strobe_n);
  // a refresh ignores the address lines and uses an internal row
  always @(negedge pins.row_strobe_n) begin
    cbr_q = col_low;
    row_q = pins.addr;
  end
  // first column fall of either strobe latches the column and looks the
  // word up then, so a write to the same cell just before is seen
  always @(posedge col_low) begin
    if (!pins.row_strobe_n) begin
      col_q = pins.addr;
      word  = mem.exists(int'({row_q, col_q})) ? mem[int'({row_q, col_q})] : 16'h0000;
    end
  end
  // each lane writes on its own strobe; unwritten words read as zero
  task automatic put(input int lane);
    int k;
    k = int'({row_q, pins.addr});
    if (!mem.exists(k)) mem[k] = 16'h0000;
    mem[k][lane*8 +: 8] = pins.dq_o[lane*8 +: 8];
  endtask : put
  always @(negedge pins.low_byte_column_strobe_n)
    if (!pins.row_strobe_n && !pins.write_n && !cbr_q) put(0);
  always @(negedge pins.high_byte_column_strobe_n)
    if (!pins.row_strobe_n && !pins.write_n && !cbr_q) put(1);
  // outputs only while row, column and enable are all active
  assign drive = !pins.row_strobe_n && col_low && !cbr_q && pins.write_n
                 && !pins.output_enable_n;
  always @(negedge drive) last_q = word;
  // released bus shows the inverse, never a convenient stale value
  assign dq = drive ? word : ~last_q;
endmodule : edc_mem_model
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// bench top
// ------------------------------------------------------------
module testbench;
  import edc_pkg::*;
  logic         ref_clk;
  logic         reset;
  logic         req_valid;
  logic         req_ready;
  logic         rd_valid;
  edc_req_type  req;
  edc_pins_type mem_pins;
  logic [15:0]  rd_data;
  logic [15:0]  mem_dq;
  logic [15:0]  dq_i;
  logic [15:0]  ref_mem [int];
  logic [15:0]  exp_q [$];
  logic [19:0]  pool [6];
  int           fail_count = 0;
  int           samples_checked = 0;
  // controller drive wins only while it enables its pins
  assign dq_i = mem_pins.dq_oe ? mem_pins.dq_o : mem_dq;
  // short pause and refresh spacing keep the run brief
  edc_ctrl #(.INIT_CYC(20), .REFI_CYC(40)) u_dut (
    .ref_clk(ref_clk), .reset(reset), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid),
    .mem_pins(mem_pins), .dq_i(dq_i));
  edc_mem_model u_mem (.pins(mem_pins), .dq(mem_dq));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  function automatic logic [15:0] merge(input logic [15:0] o, d, input logic [1:0] be);
    return {be[1] ? d[15:8] : o[15:8], be[0] ? d[7:0] : o[7:0]};
  endfunction : merge
  task automatic check(input logic [39:0] seen, want, input string what);
    samples_checked++;
    if (seen !== want) begin
      fail_count++;
      $display("MISMATCH %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check
  task automatic complete_run;
    if (fail_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  // offer at the falling edge, hold until a ready edge takes it
  task automatic push(input logic w, input logic [1:0] be, input logic [19:0] a,
                      input logic [15:0] d);
    logic [15:0] old;
    req = '{wr: w, be: be, addr: a, data: d};
    req_valid = 1'b1;
    for (int n = 0; n < 3000 && req_ready !== 1'b1; n++)
      @(negedge ref_clk);
    @(negedge ref_clk);
    old = ref_mem.exists(int'(a)) ? ref_mem[int'(a)] : 16'h0000;
    if (!w)
      exp_q.push_back(old);
    else
      ref_mem[int'(a)] = merge(old, d, be);
  endtask : push
  // every read result against the bench's own copy of memory
  always @(negedge ref_clk) if (rd_valid === 1'b1) begin
    check(40'(rd_data), 40'(exp_q.pop_front()), "read data");
  end
  initial begin
    reset = 1'b1;
    req_valid = 1'b0;
    req = '0;
    pool = '{20'h00000, 20'hfffff, 20'h003ff, 20'hffc00, 20'h12345, 20'h0ab00};
    void'($urandom(32'h2e30));
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    check(40'(mem_pins), 40'(EDC_PINS_IDLE), "pins in reset");
    check(40'(req_ready), 40'h1, "ready in reset");
    reset = 1'b0;
    // fill the fifo while the pause runs, every lane mask once
    for (int i = 0; i < 4; i++)
      push(1'b1, 2'(i), pool[i], 16'ha5c3 ^ 16'(i));
    check(40'(req_ready), 40'h0, "fifo full");
    check(40'(mem_pins), 40'(EDC_PINS_IDLE), "pins in pause");
    for (int i = 0; i < 60; i++) begin
      if ($urandom % 4 == 0) begin
        req_valid = 1'b0;
        repeat (1 + $urandom % 20) @(negedge ref_clk);
      end
      push($urandom % 2 == 1, 2'($urandom), pool[$urandom % 6], 16'($urandom));
    end
    for (int i = 0; i < 6; i++)
      push(1'b0, 2'b11, pool[i], 16'h0000);
    req_valid = 1'b0;
    for (int n = 0; n < 4000 && exp_q.size() != 0; n++)
      @(negedge ref_clk);
    check(40'(exp_q.size()), 40'h0, "reads outstanding");
    complete_run();
  end
  // hang guard, far beyond the few thousand cycles expected
  initial begin
    #(8 * 40000);
    fail_count++;
    complete_run();
  end
endmodule : testbench
`default_nettype wire
